// ### exec_pkg.sv
// Shared constants and carrier types for the table-read / exclusive-OR / zero-test unit
package exec_pkg;
  localparam int unsigned INSTR_W = 14;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned FADDR_W = 7;
  localparam int unsigned PADDR_W = 16;
  localparam int unsigned PTR_HI_W = 8;

  // Fixed encodings and field layouts
  localparam logic [13:0] OP_TABLE_LOWER = 14'h0050;
  localparam logic [13:0] OP_TABLE_UPPER = 14'h0058;
  localparam logic [6:0] PFX_NULL_TEST = 7'h11;
  localparam logic [5:0] PFX_LIT_EXOR = 6'h1f;
  localparam logic [5:0] PFX_FILE_EXOR = 6'h06;
  localparam int unsigned DEST_BIT = 7;
  localparam int unsigned ROM_HI_LSB = 8;
  localparam int unsigned ROM_HI_W = 6;
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  typedef enum logic [2:0] {
    OP_NONE,
    OP_TAB_LO,
    OP_TAB_HI,
    OP_NULL_TEST,
    OP_LIT_EXOR,
    OP_FILE_EXOR
  } op_kind_t;

  typedef struct packed {
    op_kind_t kind;
    logic dest_file;
    logic [FADDR_W-1:0] faddr;
    logic [DATA_W-1:0] literal;
  } decoded_t;

  // Register-file write request
  typedef struct packed {
    logic en;
    logic [FADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } file_wr_t;

  // Program-memory read request
  typedef struct packed {
    logic en;
    logic [PADDR_W-1:0] addr;
  } rom_rd_t;
endpackage

// ### exec_decode.sv
// Combinational instruction classifier for the unit
`timescale 1ns/1ps
module exec_decode (
  // Instruction word
  input wire logic [exec_pkg::INSTR_W-1:0] i_instr,
  // Decoded fields
  output exec_pkg::decoded_t o_dec
);
  import exec_pkg::*;

  always_comb begin
    o_dec = '0;
    o_dec.kind = OP_NONE;
    o_dec.dest_file = i_instr[DEST_BIT];
    o_dec.faddr = i_instr[FADDR_W-1:0];
    o_dec.literal = i_instr[DATA_W-1:0];
    if (i_instr == OP_TABLE_LOWER) begin
      o_dec.kind = OP_TAB_LO;
    end else if (i_instr == OP_TABLE_UPPER) begin
      o_dec.kind = OP_TAB_HI;
    end else if (i_instr[INSTR_W-1 -: $bits(PFX_NULL_TEST)] == PFX_NULL_TEST) begin
      o_dec.kind = OP_NULL_TEST;
    end else if (i_instr[INSTR_W-1 -: $bits(PFX_LIT_EXOR)] == PFX_LIT_EXOR) begin
      o_dec.kind = OP_LIT_EXOR;
    end else if (i_instr[INSTR_W-1 -: $bits(PFX_FILE_EXOR)] == PFX_FILE_EXOR) begin
      o_dec.kind = OP_FILE_EXOR;
    end
  end
endmodule

// ### exec_unit.sv
// Execution unit for table reads, exclusive-OR and zero test
// What this block does
// - Upper table read loads accumulator with high byte of ROM at pointer.
// - Pattern 0x0050 is lower table read; no operands, flags untouched.
// - Each table read takes two instruction cycles before the next.
// - Zero test sets zero flag when addressed register is zero; one cycle.
// - Literal exclusive-OR replaces accumulator and updates zero flag.
// - Register exclusive-OR writes accumulator (d=0) or register (d=1); updates zero.
`timescale 1ns/1ps
module exec_unit (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_n,
  // Instruction issue, one per i_cycle_en
  input wire logic i_cycle_en,
  input wire logic i_valid,
  input wire logic [exec_pkg::INSTR_W-1:0] i_instr,
  // Register-file read port, combinational on o_file_raddr
  input wire logic [exec_pkg::DATA_W-1:0] i_file_rdata,
  // Table pointer sources
  input wire logic [exec_pkg::PTR_HI_W-1:0] i_table_pointer_upper,
  input wire logic [exec_pkg::DATA_W-1:0] i_indirect_select_reg,
  // Program-memory data, valid the cycle after the request
  input wire logic [exec_pkg::INSTR_W-1:0] i_rom_data,
  // Accumulator and flags
  output logic [exec_pkg::DATA_W-1:0] o_acc,
  output logic o_zero,
  output logic o_busy,
  output logic o_done,
  // Register-file ports
  output logic [exec_pkg::FADDR_W-1:0] o_file_raddr,
  output exec_pkg::file_wr_t o_file_wr,
  // Program-memory read
  output exec_pkg::rom_rd_t o_rom_rd
);
  import exec_pkg::*;

  // ****************************************
  // Reset synchroniser
  // ****************************************
  // Release passes two flops so every state flop leaves reset on one edge
  logic rst_meta_q;
  logic rst_sync_q;

  always_ff @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  // ****************************************
  // State
  // ****************************************
  typedef enum logic {
    ST_IDLE,
    ST_TABLE
  } phase_t;

  typedef struct packed {
    // Outputs are fields here, so each one comes straight from a flop
    phase_t phase;
    logic upper;
    logic [DATA_W-1:0] acc;
    logic zero;
    logic busy;
    logic done;
    logic [FADDR_W-1:0] raddr;
    file_wr_t wr;
    rom_rd_t rd;
  } state_t;

  state_t s_q;
  state_t s_d;
  decoded_t dec;
  logic take;
  logic [PADDR_W-1:0] table_ptr;
  logic [DATA_W-1:0] operand;
  logic [DATA_W-1:0] result;
  logic result_zero;
  logic operand_zero;
  logic [DATA_W-1:0] rom_byte;

  // ****************************************
  // Decode
  // ****************************************
  exec_decode u_decode (
    .i_instr(i_instr),
    .o_dec(dec)
  );

  // Register read data must already match the f field when the request is taken
  // A held request is only taken on an instruction cycle with no table read open
  assign take = i_cycle_en && i_valid &&
                (s_q.phase == ST_IDLE);

  // ****************************************
  // Table pointer
  // ****************************************
  // High register over indirect select bits 7..0; captured at issue
  assign table_ptr = {i_table_pointer_upper, i_indirect_select_reg};

  // ****************************************
  // Operand path
  // ****************************************
  // Both exclusive-OR forms share one gate array; only the operand source differs
  always_comb begin
    operand = i_file_rdata;
    if (dec.kind == OP_LIT_EXOR) begin
      operand = dec.literal;
    end
    result = s_q.acc ^ operand;
    result_zero = (result == ZERO_BYTE);
    // Zero test looks at the register alone, never at the accumulator
    operand_zero = (i_file_rdata == ZERO_BYTE);
  end

  // ****************************************
  // Table word byte select
  // ****************************************
  // A 14-bit word has only six bits above the low byte; the rest read as zero
  always_comb begin
    rom_byte = i_rom_data[DATA_W-1:0];
    if (s_q.upper) begin
      rom_byte = {{(DATA_W-ROM_HI_W){1'b0}},
                  i_rom_data[ROM_HI_LSB +: ROM_HI_W]};
    end
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.wr.en = 1'b0;
    s_d.rd.en = 1'b0;
    s_d.raddr = dec.faddr;
    unique case (s_q.phase)
      ST_IDLE: begin
        if (take) begin
          unique case (dec.kind)
            OP_TAB_LO, OP_TAB_HI: begin
              s_d.rd.en = 1'b1;
              s_d.rd.addr = table_ptr;
              s_d.upper = (dec.kind == OP_TAB_HI);
              s_d.phase = ST_TABLE;
              s_d.busy = 1'b1;
            end
            OP_NULL_TEST: begin
              // Only sets; a nonzero register leaves the flag as it was
              if (operand_zero) begin
                s_d.zero = 1'b1;
              end
              s_d.done = 1'b1;
            end
            OP_LIT_EXOR: begin
              s_d.acc = result;
              s_d.zero = result_zero;
              s_d.done = 1'b1;
            end
            OP_FILE_EXOR: begin
              if (dec.dest_file) begin
                s_d.wr.en = 1'b1;
                s_d.wr.addr = dec.faddr;
                s_d.wr.data = result;
              end else begin
                s_d.acc = result;
              end
              s_d.zero = result_zero;
              s_d.done = 1'b1;
            end
            OP_NONE: begin
              // Opcodes outside this unit leave the accumulator, zero flag and busy as they were; done clears and the read address follows f
              s_d.done = 1'b0;
            end
            default: begin
              s_d.done = 1'b0;
            end
          endcase
        end
      end
      ST_TABLE: begin
        // Second instruction cycle: zero flag untouched; accumulator loads, busy clears and done pulses
        // Program data is only promised at the next cycle enable, so wait for it
        if (i_cycle_en) begin
          s_d.acc = rom_byte;
          s_d.phase = ST_IDLE;
          s_d.busy = 1'b0;
          s_d.done = 1'b1;
        end
      end
    endcase
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge i_clock or negedge rst_sync_q) begin
    if (!rst_sync_q) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign o_acc = s_q.acc;
  assign o_zero = s_q.zero;
  assign o_busy = s_q.busy;
  assign o_done = s_q.done;
  assign o_file_raddr = s_q.raddr;
  assign o_file_wr = s_q.wr;
  assign o_rom_rd = s_q.rd;
endmodule

// ### exec_unit_sva.sv
// Assertion checker for the table-read / exclusive-OR / zero-test unit
`timescale 1ns/1ps
module exec_unit_sva import exec_pkg::*; (
  input wire logic i_clock, i_rst_n, i_cycle_en, i_valid,
  input wire logic [13:0] i_instr,
  input wire logic [7:0] i_file_rdata, i_table_pointer_upper, i_indirect_select_reg, o_acc,
  input wire logic o_zero, o_busy, o_done,
  input wire file_wr_t o_file_wr,
  input wire rom_rd_t o_rom_rd
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  logic tk, tab, fx;
  assign tk = i_cycle_en && i_valid && !o_busy;
  assign tab = tk && (i_instr == OP_TABLE_LOWER || i_instr == OP_TABLE_UPPER);
  assign fx = tk && i_instr[13:8] == PFX_FILE_EXOR;
  AST_LIT: assert property (tk && i_instr[13:8] == PFX_LIT_EXOR |=> o_done &&
    o_acc == ($past(o_acc) ^ $past(i_instr[7:0])) && o_zero == (o_acc == ZERO_BYTE))
    else $error("literal exclusive-OR result wrong");
  AST_FXW: assert property (fx && !i_instr[DEST_BIT] |=>
    o_acc == ($past(o_acc) ^ $past(i_file_rdata)) && !o_file_wr.en)
    else $error("register exclusive-OR to accumulator wrong");
  AST_FXF: assert property (fx && i_instr[DEST_BIT] |=> o_file_wr.en && $stable(o_acc) &&
    o_file_wr.addr == $past(i_instr[6:0]) && o_file_wr.data == ($past(o_acc) ^ $past(i_file_rdata)))
    else $error("register exclusive-OR write-back wrong");
  AST_FXZ: assert property (fx |=> o_zero == (($past(o_acc) ^ $past(i_file_rdata)) == ZERO_BYTE))
    else $error("register exclusive-OR zero flag wrong");
  AST_NULL: assert property (tk && i_instr[13:7] == PFX_NULL_TEST && i_file_rdata == ZERO_BYTE
    |=> o_zero && o_done && $stable(o_acc))
    else $error("zero test did not set zero flag");
  AST_TREQ: assert property (tab |=> o_busy && !o_done && o_rom_rd.en &&
    o_rom_rd.addr == {$past(i_table_pointer_upper), $past(i_indirect_select_reg)})
    else $error("table read request wrong");
  AST_TTWO: assert property (tab ##1 i_cycle_en |=> o_done && !o_busy)
    else $error("table read not done in two cycles");
  AST_TFLG: assert property (o_done && $past(o_busy) |-> $stable(o_zero))
    else $error("table read changed zero flag");
  AST_THLD: assert property (o_busy && !i_cycle_en |=> o_busy && !o_done && $stable(o_acc))
    else $error("table read advanced without a cycle enable");
endmodule
bind exec_unit exec_unit_sva chk_u (.i_clock, .i_rst_n, .i_cycle_en, .i_valid, .i_instr,
  .i_file_rdata, .i_table_pointer_upper, .i_indirect_select_reg, .o_acc, .o_zero, .o_busy,
  .o_done, .o_file_wr, .o_rom_rd);

// ### exec_unit_bench.sv
// Self-checking testbench for the table-read / exclusive-OR / zero-test unit
`timescale 1ns/1ps
module exec_unit_bench;
  import exec_pkg::*;
  logic i_clock = 0, i_rst_n = 0, i_cycle_en = 1, i_valid = 0;
  logic [13:0] i_instr = 14'h0000;
  logic [7:0] i_file_rdata = 8'h00, i_table_pointer_upper = 8'h00, i_indirect_select_reg = 8'h00;
  logic [13:0] i_rom_data;
  logic [7:0] o_acc;
  logic o_zero, o_busy, o_done;
  logic [6:0] o_file_raddr;
  file_wr_t o_file_wr;
  rom_rd_t o_rom_rd;
  int bad_count = 0, n_checks = 0;
  // Program memory: pattern of the address, so a wrong pointer shows
  assign i_rom_data = o_rom_rd.addr[13:0] ^ 14'h2a5c;
  exec_unit dut_u (.i_clock, .i_rst_n, .i_cycle_en, .i_valid, .i_instr, .i_file_rdata,
    .i_table_pointer_upper, .i_indirect_select_reg, .i_rom_data, .o_acc, .o_zero, .o_busy,
    .o_done, .o_file_raddr, .o_file_wr, .o_rom_rd);
  initial forever #4 i_clock = ~i_clock;
  // ****************
  // Shared tasks
  // ****************
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic results();
    if (bad_count == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic op(input logic [13:0] ins, input logic [7:0] fd);
    @(posedge i_clock);
    i_valid <= 1'b1;
    i_instr <= ins;
    i_file_rdata <= fd;
    @(posedge i_clock);
    i_valid <= 1'b0;
    #1;
  endtask
  // ****************
  // Scenarios
  // ****************
  task automatic t_exor();
    op({PFX_LIT_EXOR, 8'h5a}, 8'h00);
    chk({o_done, o_zero, o_acc}, 10'h25a);
    op({PFX_LIT_EXOR, 8'h5a}, 8'h00);
    chk({o_zero, o_acc}, 9'h100);
    op({PFX_FILE_EXOR, 1'b0, 7'h05}, 8'haf);
    chk({o_file_wr.en, o_zero, o_acc}, 10'h0af);
    op({PFX_FILE_EXOR, 1'b1, 7'h7f}, 8'haf);
    chk(o_file_wr, {1'b1, 7'h7f, 8'h00});
    chk({o_zero, o_acc}, 9'h1af);
    chk(o_file_raddr, 7'h7f);
  endtask
  // Table read paced by a sparse cycle enable, then a near-miss opcode is ignored
  task automatic t_slow();
    @(posedge i_clock);
    i_cycle_en <= 1'b0;
    i_valid <= 1'b1;
    i_instr <= OP_TABLE_LOWER;
    i_indirect_select_reg <= 8'h34;
    @(posedge i_clock);
    i_cycle_en <= 1'b1;
    #1 chk({o_done, o_busy, o_rom_rd.en}, 3'b000);
    @(posedge i_clock);
    i_cycle_en <= 1'b0;
    i_valid <= 1'b0;
    #1 chk({o_done, o_busy, o_rom_rd}, {2'b01, 1'b1, 8'hfd, 8'h34});
    @(posedge i_clock);
    i_cycle_en <= 1'b1;
    #1 chk({o_done, o_busy, o_acc}, {2'b01, 8'h17});
    @(posedge i_clock);
    #1 chk({o_done, o_busy, o_acc}, {2'b10, 8'h34 ^ 8'h5c});
    op(14'h0051, 8'h00);
    chk({o_done, o_acc}, 9'h068);
  endtask
  task automatic t_null();
    op({PFX_LIT_EXOR, 8'h0f}, 8'h00);
    op({PFX_NULL_TEST, 7'h12}, 8'h55);
    chk({o_zero, o_acc}, 9'h0a0);
    op({PFX_NULL_TEST, 7'h12}, 8'h00);
    chk({o_done, o_zero, o_acc}, 10'h3a0);
  endtask
  // A second instruction held during the busy cycle must be ignored
  task automatic t_tab(input logic [13:0] ins, input logic [7:0] ph, sel, exp);
    logic z;
    z = o_zero;
    @(posedge i_clock);
    i_valid <= 1'b1;
    i_instr <= ins;
    i_table_pointer_upper <= ph;
    i_indirect_select_reg <= sel;
    @(posedge i_clock);
    i_instr <= {PFX_LIT_EXOR, 8'hff};
    #1 chk({o_done, o_busy, o_rom_rd}, {2'b01, 1'b1, ph, sel});
    @(posedge i_clock);
    i_valid <= 1'b0;
    #1 chk({o_done, o_busy, o_zero, o_acc}, {2'b10, z, exp});
    @(posedge i_clock);
    #1 chk(o_acc, exp);
  endtask
  initial begin
    repeat (2) @(posedge i_clock);
    i_rst_n <= 1'b1;
    repeat (3) @(posedge i_clock);
    t_exor();
    t_null();
    t_tab(OP_TABLE_LOWER, 8'h02, 8'hff, 8'hff ^ 8'h5c);
    t_tab(OP_TABLE_UPPER, 8'hfd, 8'hc1, {2'b00, 6'h3d ^ 6'h2a});
    t_slow();
    results();
  end
  initial begin
    #20000;
    bad_count++;
    results();
  end
endmodule
